// File: rtl/sdprp_mem.sv
// Byte-writable memory array with registered read data
`timescale 1ns/1ps
module sdprp_mem (
    input wire logic ref_clk,
    input wire logic mem_en,
    input wire logic wr_en,
    input wire logic [sdprp_pkg::NBYTE-1:0] byte_wr,
    input wire logic [sdprp_pkg::ADDR_W-1:0] addr,
    input wire logic [sdprp_pkg::DATA_W-1:0] wdata,
    output logic [sdprp_pkg::DATA_W-1:0] rdata_r
);
    import sdprp_pkg::*;

    logic [DATA_W-1:0] mem [DEPTH];

    // Whole write done in one edge, so no clock-low phase is needed
    always_ff @(posedge ref_clk) begin
        if (mem_en && wr_en) begin
            for (int b = 0; b < NBYTE; b++) begin
                if (byte_wr[b]) begin
                    mem[addr][b*BYTE_W +: BYTE_W] <= wdata[b*BYTE_W +: BYTE_W];
                end
            end
        end
        if (mem_en && !wr_en) begin
            rdata_r <= mem[addr];
        end
    end
endmodule : sdprp_mem

// File: rtl/sdprp_pkg.sv
// Constants and notes for one synchronous dual-port RAM port
package sdprp_pkg;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 18;
    localparam int BYTE_W = 9;
    localparam int NBYTE = 2;
    localparam int DEPTH = 32768;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 15'h0000;
    localparam logic [ADDR_W-1:0] ADDR_ONE = 15'h0001;
    localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
    localparam logic [NBYTE-1:0] EN_OFF = 2'h0;
    localparam logic [NBYTE-1:0] OE_N_OFF = 2'h3;
    localparam int UB_IDX = 1;
    localparam int LB_IDX = 0;

    typedef struct packed {
        logic [ADDR_W-1:0] cnt;
        logic lat_meta;
        logic lat_sync;
        logic [NBYTE-1:0] ft_en;
        logic [NBYTE-1:0] pipe_en;
        logic [DATA_W-1:0] pipe_data;
        logic standby;
    } sdprp_state_s;

    localparam sdprp_state_s STATE_RST = '{
        cnt: ADDR_ZERO, lat_meta: 1'b0, lat_sync: 1'b0, ft_en: EN_OFF,
        pipe_en: EN_OFF, pipe_data: DATA_RST, standby: 1'b1};
endpackage : sdprp_pkg

// File: rtl/sdprp_port.sv
// One port of the synchronous dual-port RAM with its burst address counter
`timescale 1ns/1ps
module sdprp_port (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [sdprp_pkg::ADDR_W-1:0] addr_in,
    input wire logic [sdprp_pkg::DATA_W-1:0] data_in,
    input wire logic chip_sel_low_active,
    input wire logic chip_sel_high_active,
    input wire logic read_write_n,
    input wire logic upper_byte_sel_n,
    input wire logic lower_byte_sel_n,
    input wire logic addr_load_strobe_n,
    input wire logic counter_advance_en_n,
    input wire logic counter_clear_n,
    input wire logic out_en_n,
    input wire logic output_latency_sel,
    output logic [sdprp_pkg::DATA_W-1:0] data_out,
    output logic [sdprp_pkg::NBYTE-1:0] data_oe_n,
    output logic standby
);
    import sdprp_pkg::*;

    sdprp_state_s st_r;
    sdprp_state_s st_nxt;
    logic selected;
    logic [NBYTE-1:0] byte_act;
    logic [ADDR_W-1:0] acc_addr;
    logic [DATA_W-1:0] mem_rdata;
    logic [NBYTE-1:0] drive_en;

    assign selected = !chip_sel_low_active && chip_sel_high_active;
    assign byte_act[UB_IDX] = !upper_byte_sel_n;
    assign byte_act[LB_IDX] = !lower_byte_sel_n;

    // Clear wins over load, load over advance; the counter follows the access address
    always_comb begin
        if (!counter_clear_n) begin
            acc_addr = ADDR_ZERO;
        end else if (!addr_load_strobe_n) begin
            acc_addr = addr_in;
        end else if (!counter_advance_en_n) begin
            acc_addr = st_r.cnt + ADDR_ONE;
        end else begin
            acc_addr = st_r.cnt;
        end
    end

    // Array is idle while deselected, which is the static power saving
    sdprp_mem u_mem (
        .ref_clk(ref_clk),
        .mem_en(selected),
        .wr_en(!read_write_n),
        .byte_wr(byte_act),
        .addr(acc_addr),
        .wdata(data_in),
        .rdata_r(mem_rdata)
    );

    always_comb begin
        st_nxt = st_r;
        st_nxt.cnt = acc_addr;
        // Latency select is static but asynchronous, so it is synchronised
        st_nxt.lat_meta = output_latency_sel;
        st_nxt.lat_sync = st_r.lat_meta;
        // Drive state for the next cycle comes from this cycle's controls
        st_nxt.ft_en = (selected && read_write_n) ? byte_act : EN_OFF;
        st_nxt.pipe_en = st_r.ft_en;
        st_nxt.pipe_data = mem_rdata;
        st_nxt.standby = !selected;
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            st_r <= STATE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Each instance owns its own clock, counter and pipeline
    assign drive_en = st_r.lat_sync ? st_r.pipe_en : st_r.ft_en;
    assign data_out = st_r.lat_sync ? st_r.pipe_data : mem_rdata;
    // Output enable is combinational so it can float the bus without a clock
    assign data_oe_n = out_en_n ? OE_N_OFF : ~drive_en;
    assign standby = st_r.standby;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    AST_CLR_ZERO: assert property (
        !counter_clear_n
        |=> st_r.cnt == ADDR_ZERO)
        else $error("Counter clear did not give address zero");

    AST_CLR_ACC: assert property (
        !counter_clear_n
        |-> acc_addr == ADDR_ZERO)
        else $error("Counter clear did not access address zero");

    AST_LOAD: assert property (
        counter_clear_n && !addr_load_strobe_n
        |=> st_r.cnt == $past(addr_in))
        else $error("Load strobe did not capture the external address");

    AST_ACC_EXT: assert property (
        counter_clear_n && !addr_load_strobe_n
        |-> acc_addr == addr_in)
        else $error("Access address is not the external address");

    AST_INC: assert property (
        counter_clear_n && addr_load_strobe_n && !counter_advance_en_n
        |=> st_r.cnt == $past(st_r.cnt) + ADDR_ONE)
        else $error("Counter advance did not add one");

    AST_INC_ACC: assert property (
        counter_clear_n && addr_load_strobe_n && !counter_advance_en_n
        |-> acc_addr == st_r.cnt + ADDR_ONE)
        else $error("Advance cycle did not use the incremented address");

    AST_CNT_FOLLOW: assert property (
        $past(nrst)
        |-> st_r.cnt == $past(acc_addr))
        else $error("Counter did not take the access address");

    AST_HOLD: assert property (
        counter_clear_n && addr_load_strobe_n && counter_advance_en_n
        |=> $stable(st_r.cnt))
        else $error("Address moved while held");

    AST_HOLD_DATA: assert property (
        (selected && read_write_n && addr_load_strobe_n && counter_advance_en_n
        && counter_clear_n && !st_r.lat_sync) ##1 (selected && read_write_n
        && addr_load_strobe_n && counter_advance_en_n && counter_clear_n && !st_r.lat_sync)
        |=> st_r.lat_sync || $stable(data_out))
        else $error("Read data changed while the address was held");

    AST_ACC_ADDR: assert property (
        addr_load_strobe_n && counter_clear_n && counter_advance_en_n
        |-> acc_addr == st_r.cnt)
        else $error("Access address is not the counter");

    // Flow-through checks also need the synchroniser settled, or the next cycle may switch mode
    AST_DESEL_FT: assert property (
        !selected && !st_r.lat_sync && !st_r.lat_meta
        |=> data_oe_n == OE_N_OFF)
        else $error("Flow-through output drove after deselect");

    AST_READ_DRIVE: assert property (
        selected && read_write_n && !st_r.lat_sync && !st_r.lat_meta
        |=> data_oe_n == (out_en_n ? OE_N_OFF : ~$past(byte_act)))
        else $error("Flow-through drive state does not follow the previous controls");

    AST_WRITE_QUIET: assert property (
        selected && !read_write_n
        |=> st_r.lat_sync || data_oe_n == OE_N_OFF)
        else $error("Output drove after a write cycle");

    AST_OE_ASYNC: assert property (
        out_en_n
        |-> data_oe_n == OE_N_OFF)
        else $error("Output drove with output enable high");

    AST_BYTE_PIPE: assert property (
        (st_r.lat_sync && st_r.lat_meta && upper_byte_sel_n) ##1 (st_r.lat_sync && st_r.lat_meta)
        |=> data_oe_n[UB_IDX])
        else $error("Upper byte drove two cycles after byte select high");

    AST_BYTE_PIPE_LO: assert property (
        (st_r.lat_sync && st_r.lat_meta && lower_byte_sel_n) ##1 (st_r.lat_sync && st_r.lat_meta)
        |=> data_oe_n[LB_IDX])
        else $error("Lower byte drove two cycles after byte select high");

    AST_PIPE_OE: assert property (
        (st_r.lat_sync && st_r.lat_meta && selected && read_write_n)
        ##1 (st_r.lat_sync && st_r.lat_meta)
        |=> out_en_n || data_oe_n == ~$past(byte_act, 2))
        else $error("Pipelined drive state is not two cycles behind the controls");

    AST_REACT_PIPE: assert property (
        (st_r.lat_sync && !selected) ##1 (st_r.lat_sync && selected)
        |=> st_r.lat_sync |-> data_oe_n == OE_N_OFF)
        else $error("Pipelined output returned after one selected cycle");

    AST_STANDBY: assert property (
        !selected
        |=> standby && (st_r.lat_sync || data_oe_n == OE_N_OFF))
        else $error("Port did not enter standby");

    AST_STANDBY_WAKE: assert property (
        selected
        |=> !standby)
        else $error("Port stayed in standby while selected");

    AST_RST_QUIET: assert property (
        disable iff (1'b0) !nrst
        |=> data_oe_n == OE_N_OFF && standby)
        else $error("Port not quiet after reset");

    AST_LAT_SYNC: assert property (
        $past(nrst) && $past(nrst, 2)
        |-> st_r.lat_sync == $past(output_latency_sel, 2))
        else $error("Latency select did not pass two flip-flops");

    AST_PIPE_DATA: assert property (
        (selected && read_write_n && st_r.lat_sync && st_r.lat_meta)
        ##1 (st_r.lat_sync && st_r.lat_meta)
        |=> data_out == $past(mem_rdata))
        else $error("Pipelined data is not one cycle behind the array data");

    COV_LOAD_READ: cover property (
        selected && read_write_n && !addr_load_strobe_n
        ##1 data_oe_n != OE_N_OFF);

    COV_ADVANCE: cover property (
        !counter_advance_en_n && addr_load_strobe_n
        ##1 !counter_advance_en_n && addr_load_strobe_n);

    COV_CLEAR_WRITE: cover property (
        !counter_clear_n && selected && !read_write_n);

    COV_PIPE_READ: cover property (
        st_r.lat_sync && selected && read_write_n
        ##2 data_oe_n == EN_OFF);

    COV_HOLD_TWICE: cover property (
        addr_load_strobe_n && counter_advance_en_n && selected
        ##1 addr_load_strobe_n && counter_advance_en_n && selected);
endmodule : sdprp_port

// File: verif/sdprp_ctrl_model.sv
// Behavioural memory controller model that drives the pins of one port
`timescale 1ns/1ps
module sdprp_ctrl_model (
    input wire logic ref_clk,
    input wire logic [40:0] cmd,
    output logic [40:0] pins
);
    logic [17:0] last_r = 18'h00000;
    // Outside writes the data lines toggle, so a stale word can never pass for a match
    always_comb begin
        // Address and controls pass as one shared bus, as every bank or slice would see them
        pins = cmd;
        if (cmd[38] || cmd[40] || !cmd[39]) begin
            pins[17:0] = ~last_r;
        end
    end
    always @(posedge ref_clk) begin
        last_r <= pins[17:0];
    end
endmodule : sdprp_ctrl_model

// File: verif/test_sdprp_port.sv
// Self-checking bench for one RAM port
`timescale 1ns/1ps
`define CHK(a, b, m) begin checks++; if ((a) !== (b)) begin miscompares++; \
    $display("MISMATCH %0t %s", $time, m); end end
module test_sdprp_port;
    import sdprp_pkg::*;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic out_en_n = 1'b0;
    logic output_latency_sel = 1'b0;
    logic [40:0] cmd = {8'hE3, 33'h000000000};
    logic [40:0] pins;
    logic [DATA_W-1:0] data_out;
    logic [NBYTE-1:0] data_oe_n;
    logic standby;
    int checks = 0;
    int miscompares = 0;
    // Row: controls, address, write data, expected drive, standby, read data
    logic [61:0] rows [13] = '{
        {8'h43, 15'h0005, 18'h12345, 2'h3, 1'b0, 18'h00000},
        {8'h43, 15'h0006, 18'h0ABCD, 2'h3, 1'b0, 18'h00000},
        {8'h63, 15'h0005, 18'h00000, 2'h0, 1'b0, 18'h12345},
        {8'h65, 15'h0000, 18'h00000, 2'h0, 1'b0, 18'h0ABCD},
        {8'h67, 15'h0000, 18'h00000, 2'h0, 1'b0, 18'h0ABCD},
        {8'h67, 15'h0000, 18'h00000, 2'h0, 1'b0, 18'h0ABCD},
        {8'h46, 15'h1234, 18'h3FFFF, 2'h3, 1'b0, 18'h00000},
        {8'h66, 15'h1234, 18'h00000, 2'h0, 1'b0, 18'h3FFFF},
        {8'h73, 15'h0005, 18'h00000, 2'h2, 1'b0, 18'h00000},
        {8'hE3, 15'h0005, 18'h00000, 2'h3, 1'b1, 18'h00000},
        {8'h23, 15'h0005, 18'h00000, 2'h3, 1'b1, 18'h00000},
        {8'h4B, 15'h0005, 18'h00000, 2'h3, 1'b0, 18'h00000},
        {8'h63, 15'h0005, 18'h00000, 2'h0, 1'b0, 18'h00145}
    };
    always #50 ref_clk = ~ref_clk;
    sdprp_ctrl_model ctrl_u (.ref_clk(ref_clk), .cmd(cmd), .pins(pins));
    sdprp_port dut_u (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .addr_in(pins[32:18]),
        .data_in(pins[17:0]),
        .chip_sel_low_active(pins[40]),
        .chip_sel_high_active(pins[39]),
        .read_write_n(pins[38]),
        .upper_byte_sel_n(pins[37]),
        .lower_byte_sel_n(pins[36]),
        .addr_load_strobe_n(pins[35]),
        .counter_advance_en_n(pins[34]),
        .counter_clear_n(pins[33]),
        .out_en_n(out_en_n),
        .output_latency_sel(output_latency_sel),
        .data_out(data_out),
        .data_oe_n(data_oe_n),
        .standby(standby)
    );
    task automatic report_and_stop;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop
    // About 50 cycles are needed; a hang is cut off well beyond that
    initial begin
        #100000;
        miscompares++;
        report_and_stop();
    end
    initial begin
        repeat (10) @(negedge ref_clk);
        `CHK(data_oe_n, OE_N_OFF, "reset drive")
        `CHK(standby, 1'b1, "reset standby")
        repeat (10) @(negedge ref_clk);
        nrst = 1'b1;
        for (int i = 0; i < 13; i++) begin
            cmd <= rows[i][61:21];
            @(negedge ref_clk);
            `CHK(data_oe_n, rows[i][20:19], "drive state")
            `CHK(standby, rows[i][18], "standby")
            if (rows[i][20:19] == 2'h0) `CHK(data_out, rows[i][17:0], "read data")
        end
        out_en_n = 1'b1;
        #1;
        `CHK(data_oe_n, OE_N_OFF, "output enable")
        out_en_n = 1'b0;
        // Latency select goes through a synchroniser, so give it three edges
        output_latency_sel = 1'b1;
        repeat (3) @(negedge ref_clk);
        cmd <= {8'h63, 15'h0006, 18'h00000};
        @(negedge ref_clk);
        `CHK(data_out, 18'h00145, "pipe stage")
        cmd <= {8'h63, 15'h0000, 18'h00000};
        @(negedge ref_clk);
        `CHK(data_out, 18'h0ABCD, "pipe first")
        @(negedge ref_clk);
        `CHK(data_out, 18'h3FFFF, "pipe next")
        `CHK(data_oe_n, 2'h0, "pipe drive")
        cmd <= {8'hE3, 15'h0006, 18'h00000};
        @(negedge ref_clk);
        cmd <= {8'h63, 15'h0006, 18'h00000};
        @(negedge ref_clk);
        `CHK(data_oe_n, OE_N_OFF, "pipe wake one")
        cmd <= {8'h73, 15'h0005, 18'h00000};
        @(negedge ref_clk);
        `CHK(data_oe_n, 2'h0, "pipe wake two")
        `CHK(data_out, 18'h0ABCD, "pipe wake data")
        cmd <= {8'h43, 15'h0006, 18'h2A5A5};
        @(negedge ref_clk);
        `CHK(data_oe_n, 2'h2, "pipe upper float")
        `CHK(data_out[8:0], 9'h145, "pipe lower byte")
        cmd <= {8'hE3, 15'h0006, 18'h00000};
        @(negedge ref_clk);
        // The turnaround no-operation is deselected and writes nothing, yet the controller writes its location again
        cmd <= {8'h43, 15'h0006, 18'h2A5A5};
        @(negedge ref_clk);
        cmd <= {8'h63, 15'h0006, 18'h00000};
        repeat (2) @(negedge ref_clk);
        `CHK(data_out, 18'h2A5A5, "rewritten word")
        `CHK(data_oe_n, 2'h0, "rewritten drive")
        nrst = 1'b0;
        cmd <= {8'hE3, 33'h000000000};
        repeat (2) @(negedge ref_clk);
        `CHK(data_oe_n, OE_N_OFF, "mid reset drive")
        `CHK(standby, 1'b1, "mid reset standby")
        nrst = 1'b1;
        @(negedge ref_clk);
        `CHK(data_oe_n, OE_N_OFF, "release drive")
        `CHK(standby, 1'b1, "release standby")
        report_and_stop();
    end
endmodule : test_sdprp_port
